// ---- verilog/ish_stop_holdoff.sv ----
// Module: stop-mode holdoff, bus condition flags and their registers
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module ish_stop_holdoff (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic ctrl_enable,
  input wire logic module_irq_enable,
  input wire logic stop_req,
  output logic stop_ack,
  output logic irq,
  output logic module_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ish_pkg::ish_top_state_type st; // All registered state
  ish_pkg::ish_top_state_type next_st; // Next state
  ish_pkg::ish_bus_evt_type evt; // Bus events this cycle
  logic scl_filt; // Filtered clock line
  logic sda_filt; // Filtered data line
  logic byte_done; // Acknowledge clock of a byte has ended
  logic wr_filter; // Write to the holdoff/filter register
  logic rd_status; // Read of the event status register
  logic [3:0] events; // New sticky events this cycle

  // Register access decode, written once and used three times
  function automatic logic hit(input logic strobe,
                               input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = strobe && (addr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // Line conditioning
  // ----------------------------------------------------------------
  // Both lines share one width field, as the controller does
  ish_glitch_filter #(.CNT_W(ish_pkg::ISH_FLT_W)) u_scl_filter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin(scl_pin),
    .width(st.glitch_filter_width),
    .level(scl_filt)
  );

  ish_glitch_filter #(.CNT_W(ish_pkg::ISH_FLT_W)) u_sda_filter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin(sda_pin),
    .width(st.glitch_filter_width),
    .level(sda_filt)
  );

  ish_cond_detect u_detect (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .scl(scl_filt),
    .sda(sda_filt),
    .evt(evt)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    wr_filter = hit(reg_wr, reg_addr, ish_pkg::ISH_OFS_FILTER);
    rd_status = hit(reg_rd, reg_addr, ish_pkg::ISH_OFS_IRQ_STATUS);
    byte_done = evt.scl_fall && st.busy
                && (st.bit_cnt == ish_pkg::ISH_BITS_PER_BYTE);
    events = '0;

    // Transfer tracking: a start opens, a stop closes
    if (evt.start) begin
      next_st.busy = 1'b1;
      next_st.bit_cnt = '0;
    end else if (evt.stop) begin
      next_st.busy = 1'b0;
      next_st.bit_cnt = '0;
    end else if (st.busy && evt.scl_rise) begin
      // Saturate so a runaway clock cannot wrap the count
      if (st.bit_cnt != ish_pkg::ISH_BITS_PER_BYTE) begin
        next_st.bit_cnt = st.bit_cnt + 4'h1;
      end
    end else if (byte_done) begin
      next_st.bit_cnt = '0;
    end

    // Control fields of the holdoff/filter register
    if (wr_filter) begin
      next_st.stop_holdoff_enable = reg_wdata[ish_pkg::ISH_POS_HOLD];
      next_st.stop_start_irq_enable = reg_wdata[ish_pkg::ISH_POS_STOP_START_IRQ_ENABLE];
      next_st.glitch_filter_width = reg_wdata[ish_pkg::ISH_FLT_W-1:0];
    end

    // Flags: a one clears, a zero leaves alone, detection wins
    if (wr_filter && reg_wdata[ish_pkg::ISH_POS_BUS_STOP_FLAG]) begin
      next_st.bus_stop_flag = 1'b0;
    end
    if (evt.stop) begin
      next_st.bus_stop_flag = 1'b1;
    end
    if (wr_filter && reg_wdata[ish_pkg::ISH_POS_BUS_START_FLAG]) begin
      next_st.bus_start_flag = 1'b0;
    end
    if (evt.start) begin
      next_st.bus_start_flag = 1'b1;
    end

    // Stop-mode handshake
    case (st.hold)
      ish_pkg::ISH_IDLE: begin
        if (stop_req) begin
          // No gating when disabled, idle or switched off
          if (!st.stop_holdoff_enable || !ctrl_enable || !st.busy) begin
            next_st.hold = ish_pkg::ISH_ACKED;
          end else begin
            next_st.hold = ish_pkg::ISH_HOLD;
          end
        end
      end
      ish_pkg::ISH_HOLD: begin
        if (!stop_req) begin
          // Request withdrawn before the byte ended
          next_st.hold = ish_pkg::ISH_IDLE;
        end else if (byte_done || !st.busy || !ctrl_enable) begin
          next_st.hold = ish_pkg::ISH_ACKED;
        end
      end
      ish_pkg::ISH_ACKED: begin
        // Stay acknowledged until the power controller lets go
        if (!stop_req) begin
          next_st.hold = ish_pkg::ISH_IDLE;
        end
      end
      default: begin
        next_st.hold = ish_pkg::ISH_IDLE;
      end
    endcase

    // Sticky event status: read clears, new events win
    events[ish_pkg::ISH_IRQ_STOP] = evt.stop;
    events[ish_pkg::ISH_IRQ_START] = evt.start;
    events[ish_pkg::ISH_IRQ_BYTE] = byte_done;
    events[ish_pkg::ISH_IRQ_ACK] = (st.hold != ish_pkg::ISH_ACKED)
                                   && (next_st.hold == ish_pkg::ISH_ACKED);
    if (rd_status) begin
      next_st.irq_status = '0;
    end
    next_st.irq_status = next_st.irq_status | events;
    if (hit(reg_wr, reg_addr, ish_pkg::ISH_OFS_IRQ_MASK)) begin
      next_st.irq_mask = reg_wdata[ish_pkg::ISH_IRQ_W-1:0];
    end

    // Read data stand only in the cycle after the strobe
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == ish_pkg::ISH_OFS_FILTER) begin
        next_st.rdata = {st.stop_holdoff_enable, st.bus_stop_flag, st.stop_start_irq_enable, st.bus_start_flag,
                         st.glitch_filter_width};
      end else if (reg_addr == ish_pkg::ISH_OFS_IRQ_STATUS) begin
        next_st.rdata = {4'h0, st.irq_status};
      end else if (reg_addr == ish_pkg::ISH_OFS_IRQ_MASK) begin
        next_st.rdata = {4'h0, st.irq_mask};
      end else begin
        // Unmapped addresses read as zero
        next_st.rdata = 8'h00;
      end
    end

    // Outputs, taken from next values so each is one flip-flop
    next_st.stop_ack = (next_st.hold == ish_pkg::ISH_ACKED);
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    // The byte bit is sticky across a stopped clock, so a transfer
    // that completed before stop mode still interrupts on wakeup
    next_st.module_irq = module_irq_enable
      && ((next_st.stop_start_irq_enable && (next_st.bus_stop_flag || next_st.bus_start_flag))
          || next_st.irq_status[ish_pkg::ISH_IRQ_BYTE]);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything freezes while the clock enable is low
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '{hold: ish_pkg::ISH_IDLE,
              stop_holdoff_enable: ish_pkg::ISH_FILTER_RST[ish_pkg::ISH_POS_HOLD],
              stop_start_irq_enable: ish_pkg::ISH_FILTER_RST[ish_pkg::ISH_POS_STOP_START_IRQ_ENABLE],
              bus_stop_flag: ish_pkg::ISH_FILTER_RST[ish_pkg::ISH_POS_BUS_STOP_FLAG],
              bus_start_flag: ish_pkg::ISH_FILTER_RST[ish_pkg::ISH_POS_BUS_START_FLAG],
              glitch_filter_width: ish_pkg::ISH_FILTER_RST[3:0],
              irq_status: 4'h0,
              irq_mask: ish_pkg::ISH_MASK_RST,
              busy: 1'b0,
              bit_cnt: 4'h0,
              rdata: 8'h00,
              stop_ack: 1'b0,
              irq: 1'b0,
              module_irq: 1'b0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign stop_ack = st.stop_ack;
  assign irq = st.irq;
  assign module_irq = st.module_irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking ck @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  holdoff_wait_a: assert property (
    clk_en && stop_req && st.hold == ish_pkg::ISH_IDLE && st.stop_holdoff_enable
    && st.busy && ctrl_enable |=> !stop_ack)
    else $error("ack given while a byte was in flight");

  byte_end_ack_a: assert property (
    clk_en && stop_req && st.hold == ish_pkg::ISH_HOLD && byte_done
    |=> stop_ack)
    else $error("ack missing after byte end");

  idle_ack_a: assert property (
    clk_en && stop_req && st.hold == ish_pkg::ISH_IDLE && st.stop_holdoff_enable
    && (!st.busy || !ctrl_enable) |=> stop_ack)
    else $error("idle controller delayed the ack");

  no_gate_a: assert property (
    clk_en && stop_req && st.hold == ish_pkg::ISH_IDLE && !st.stop_holdoff_enable
    |=> stop_ack)
    else $error("disabled holdoff delayed the ack");

  byte_irq_a: assert property (
    clk_en && byte_done && module_irq_enable |=> module_irq)
    else $error("transfer complete did not interrupt");

  stop_set_a: assert property (
    clk_en && evt.stop |=> st.bus_stop_flag && st.irq_status[ish_pkg::ISH_IRQ_STOP])
    else $error("stop condition not flagged");

  stop_clear_a: assert property (
    clk_en && wr_filter && reg_wdata[ish_pkg::ISH_POS_BUS_STOP_FLAG] && !evt.stop
    |=> !st.bus_stop_flag)
    else $error("write one did not clear stop flag");

  stop_read_a: assert property (
    clk_en && reg_rd && reg_addr == ish_pkg::ISH_OFS_FILTER
    |=> reg_rdata[ish_pkg::ISH_POS_BUS_STOP_FLAG] == $past(st.bus_stop_flag))
    else $error("stop flag read back wrong");

  stop_keep_a: assert property (
    st.bus_stop_flag && !(clk_en && wr_filter
                  && reg_wdata[ish_pkg::ISH_POS_BUS_STOP_FLAG]) |=> st.bus_stop_flag)
    else $error("stop flag dropped without a clear");

  start_set_a: assert property (
    clk_en && evt.start |=> st.bus_start_flag)
    else $error("start condition not flagged");

  cond_irq_a: assert property (
    clk_en && (evt.stop || evt.start) && module_irq_enable && st.stop_start_irq_enable
    && !wr_filter |=> module_irq)
    else $error("stop or start did not interrupt");

  // ----------------------------------------------------------------
  // Flag and filter assertions
  // ----------------------------------------------------------------
  // The start flag mirrors the stop flag, so a slip in either
  // write-one-to-clear path is caught on its own
  start_clear_a: assert property (
    clk_en && wr_filter && reg_wdata[ish_pkg::ISH_POS_BUS_START_FLAG]
    && !evt.start |=> !st.bus_start_flag)
    else $error("write one did not clear start flag");

  start_keep_a: assert property (
    st.bus_start_flag && !(clk_en && wr_filter
                   && reg_wdata[ish_pkg::ISH_POS_BUS_START_FLAG]) |=> st.bus_start_flag)
    else $error("start flag dropped without a clear");

  // The whole width field lands in one write, so the filters never
  // see a half-updated threshold
  flt_write_a: assert property (
    clk_en && wr_filter
    |=> st.glitch_filter_width == $past(reg_wdata[ish_pkg::ISH_FLT_W-1:0]))
    else $error("filter width not taken from the write");

  // ----------------------------------------------------------------
  // Handshake and register assertions
  // ----------------------------------------------------------------
  // The power controller may sample the ack at any edge, so it must
  // neither rise early nor flicker while the request stands
  hold_keep_a: assert property (
    clk_en && stop_req && st.hold == ish_pkg::ISH_HOLD && !byte_done
    && st.busy && ctrl_enable |=> !stop_ack)
    else $error("ack given before the byte ended");

  // Held until the power controller lets go
  ack_stand_a: assert property (
    clk_en && stop_req && stop_ack |=> stop_ack)
    else $error("ack dropped while the request stood");

  // A withdrawn request leaves nothing pending in any state
  ack_drop_a: assert property (
    clk_en && !stop_req |=> !stop_ack)
    else $error("ack stayed after the request fell");

  // A stop closes the transfer, so a later request is not held off
  busy_stop_a: assert property (
    clk_en && evt.stop |=> !st.busy)
    else $error("transfer still open after a stop");

  // Stale read data would be taken as a second answer by the bus
  rdata_idle_a: assert property (
    clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stood beyond its cycle");

  // Mask writes may lower the line in the same cycle; left out here
  irq_raise_a: assert property (
    clk_en && |(events & st.irq_mask) && !reg_wr |=> irq)
    else $error("unmasked event did not interrupt");

  // The outside enable gates the line whatever the flags hold
  module_irq_off_a: assert property (
    clk_en && !module_irq_enable |=> !module_irq)
    else $error("module interrupt raised while disabled");

endmodule : ish_stop_holdoff

// ---- verilog/ish_pkg.sv ----
// Package: constants and types for the stop holdoff and bus event block
//
// Overview of operation
// - Enabled holdoff delays stop ack during transfer
// - Held ack waits for current byte end
// - Idle or disabled controller acks at once
// - Holdoff disabled never delays stop entry
// - Transfer complete interrupt survives stop mode
// - Bus stop detection sets bit six flag
// - Writing one clears the bus stop flag
// - Stop flag reads one after detection
// - Start detection sets bit four flag
// - Enabled start/stop detection raises module interrupt
// - Filter absorbs glitches up to n clocks
package ish_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ISH_OFS_FILTER = 8'h06; // Holdoff/filter reg
  localparam logic [7:0] ISH_OFS_IRQ_STATUS = 8'h10; // Sticky events
  localparam logic [7:0] ISH_OFS_IRQ_MASK = 8'h11; // Event mask

  // Field positions in the holdoff/filter register
  localparam int ISH_POS_HOLD = 7;
  localparam int ISH_POS_BUS_STOP_FLAG = 6;
  localparam int ISH_POS_STOP_START_IRQ_ENABLE = 5;
  localparam int ISH_POS_BUS_START_FLAG = 4;
  localparam int ISH_FLT_W = 4; // Filter width field, bits 3:0

  // Bits of the event status and mask registers
  localparam int ISH_IRQ_STOP = 0;
  localparam int ISH_IRQ_START = 1;
  localparam int ISH_IRQ_BYTE = 2;
  localparam int ISH_IRQ_ACK = 3;
  localparam int ISH_IRQ_W = 4;

  // Values after reset
  localparam logic [7:0] ISH_FILTER_RST = 8'h00;
  localparam logic [3:0] ISH_MASK_RST = 4'h0;
  localparam logic [2:0] ISH_SYNC_RST = 3'h7; // Bus idles high

  // Clock rises per byte: eight data bits plus acknowledge
  localparam logic [3:0] ISH_BITS_PER_BYTE = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Bus events seen on the filtered lines, one-cycle pulses
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } ish_bus_evt_type;

  // Stop-mode handshake states
  typedef enum logic [2:0] {
    ISH_IDLE = 3'b001,
    ISH_HOLD = 3'b010,
    ISH_ACKED = 3'b100
  } ish_hold_state_type;

  // State of one pin filter
  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [3:0] cnt;
  } ish_filt_state_type;

  // State of the condition detector
  typedef struct packed {
    logic prev_scl;
    logic prev_sda;
  } ish_det_state_type;

  // State of the top module
  typedef struct packed {
    ish_hold_state_type hold;
    logic stop_holdoff_enable;
    logic stop_start_irq_enable;
    logic bus_stop_flag;
    logic bus_start_flag;
    logic [3:0] glitch_filter_width;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic busy;
    logic [3:0] bit_cnt;
    logic [7:0] rdata;
    logic stop_ack;
    logic irq;
    logic module_irq;
  } ish_top_state_type;

endpackage : ish_pkg

// ---- verilog/ish_glitch_filter.sv ----
// Module: pin synchroniser and programmable glitch filter for one line
`timescale 1ns/1ps
module ish_glitch_filter #(
  parameter int CNT_W = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pin,
  input wire logic [CNT_W-1:0] width,
  output logic level
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CNT_W != 4) begin : g_bad_width
    $error("ish_glitch_filter: counter must match the 4-bit field");
  end

  ish_pkg::ish_filt_state_type st; // Registered state
  ish_pkg::ish_filt_state_type next_st; // Next state
  logic stable; // Second and third stage agree

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A change counts only once the last two stages agree, so the
  // metastable first stage never reaches the counter
  always_comb begin
    next_st = st;
    next_st.sync = {st.sync[1:0], pin};
    stable = (st.sync[1] == st.sync[2]);
    if (stable && st.sync[2] != st.level) begin
      // Pass once held longer than the width; zero passes at once
      if (st.cnt >= width) begin
        next_st.level = st.sync[2];
        next_st.cnt = '0;
      end else begin
        next_st.cnt = st.cnt + 4'h1;
      end
    end else begin
      // Glitch ended or no change: restart the count
      next_st.cnt = '0;
    end
  end

  // Register, frozen while the clock enable is low
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '{sync: ish_pkg::ISH_SYNC_RST, level: 1'b1, cnt: 4'h0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign level = st.level;

  // Width zero hands the synchronised level straight through
  filter_bypass_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    clk_en && width == '0 && stable && st.sync[2] != st.level
    |=> level == $past(st.sync[2]))
    else $error("filter bypass did not pass the level");

endmodule : ish_glitch_filter

// ---- verilog/ish_cond_detect.sv ----
// Module: start, stop and clock edge detection on the filtered lines
`timescale 1ns/1ps
module ish_cond_detect (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic scl,
  input wire logic sda,
  output ish_pkg::ish_bus_evt_type evt
);

  ish_pkg::ish_det_state_type st; // Previous line levels
  ish_pkg::ish_det_state_type next_st; // Next state

  // ----------------------------------------------------------------
  // Edge decode
  // ----------------------------------------------------------------
  // Data moving while the clock stays high marks a condition
  always_comb begin
    next_st.prev_scl = scl;
    next_st.prev_sda = sda;
    evt.start = st.prev_scl && scl && st.prev_sda && !sda;
    evt.stop = st.prev_scl && scl && !st.prev_sda && sda;
    evt.scl_rise = !st.prev_scl && scl;
    evt.scl_fall = st.prev_scl && !scl;
  end

  // Register, frozen while the clock enable is low
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '{prev_scl: 1'b1, prev_sda: 1'b1};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

endmodule : ish_cond_detect

// ---- verification/ish_bus_model.sv ----
// Bus partner: a master and its slave driving both open-drain lines
`timescale 1ns/1ps
module ish_bus_model #(
  parameter int HALF = 24 // Cycles per phase, above any filter setting
) (
  input wire logic ref_clk,
  output logic scl,
  output logic sda
);
  // ----------------------------------------------------------------
  // Line drivers
  // ----------------------------------------------------------------
  // Released lines read high through their pull-ups
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // One bus phase of idle time
  task automatic hb();
    repeat (HALF) @(posedge ref_clk);
  endtask : hb

  // Start: data falls while the clock is high, then clock goes low
  task automatic start_c();
    @(posedge ref_clk);
    sda <= 1'b0;
    hb();
    scl <= 1'b0;
  endtask : start_c

  // Clock out bits first..last of v, msb first; bit 8 is the ack slot
  task automatic bits(input logic [8:0] v, input int first,
                      input int last);
    for (int i = first; i <= last; i++) begin
      hb();
      sda <= v[8-i];
      hb();
      scl <= 1'b1;
      hb();
      scl <= 1'b0;
    end
  endtask : bits

  // Stop: data rises while the clock is high, then the bus rests
  task automatic stop_c();
    hb();
    sda <= 1'b0;
    hb();
    scl <= 1'b1;
    hb();
    sda <= 1'b1;
    hb();
  endtask : stop_c

  // Short low pulse on data with the clock high; only on command
  task automatic glitch(input int g);
    @(posedge ref_clk);
    sda <= 1'b0;
    repeat (g) @(posedge ref_clk);
    sda <= 1'b1;
    hb();
  endtask : glitch
endmodule : ish_bus_model

// ---- verification/tb.sv ----
// Testbench: stop holdoff handshake, bus flags and event registers
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] GLITCH_FILTER_WIDTH = ish_pkg::ISH_OFS_FILTER;
  localparam logic [7:0] STS = ish_pkg::ISH_OFS_IRQ_STATUS;
  localparam logic [7:0] MSK = ish_pkg::ISH_OFS_IRQ_MASK;
  localparam int LIMIT = 40000; // Planned run is near 2500 cycles
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic scl;
  logic sda;
  logic ctrl_enable = 1'b1;
  logic module_irq_enable = 1'b1;
  logic stop_req = 1'b0;
  logic stop_ack;
  logic irq;
  logic module_irq;
  logic rd_d = 1'b0; // High in the cycle where read data stands
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  logic [7:0] v;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  always #2.5 ref_clk = ~ref_clk;

  ish_stop_holdoff u_ish_stop_holdoff (.ref_clk(ref_clk),
    .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_pin(scl), .sda_pin(sda),
    .ctrl_enable(ctrl_enable), .module_irq_enable(module_irq_enable),
    .stop_req(stop_req), .stop_ack(stop_ack), .irq(irq),
    .module_irq(module_irq));

  ish_bus_model u_bus (.ref_clk(ref_clk), .scl(scl), .sda(sda));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Single-bit outputs, widened so the compare stays four-state
  task automatic ck(input string name, input logic s, input logic e);
    check(name, {7'h00, s}, {7'h00, e});
  endtask : ck

  task automatic conclude();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // Wait n edges, then settle to the falling edge for sampling
  task automatic cy(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : cy

  // ----------------------------------------------------------------
  // Register bus master and stop request driver
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read strobe; the expectation waits in the queue for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic req(input logic b);
    @(posedge ref_clk);
    stop_req <= b;
  endtask : req

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_d) begin
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  // Hang guard: counts as a mismatch and closes the run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(4));
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    cy(1);
    ck("stop_ack", stop_ack, 1'b0);
    rd(GLITCH_FILTER_WIDTH, 8'h00);
    rd(MSK, 8'h00);
    rd(STS, 8'h00);
    rd(8'h3F, 8'h00);
    // Writable fields hold; flags ignore writes with no event seen
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(GLITCH_FILTER_WIDTH, v);
      rd(GLITCH_FILTER_WIDTH, v & 8'hAF);
    end
    // Strobe while the clock enable is low must be ignored
    clk_en <= 1'b0;
    wr(GLITCH_FILTER_WIDTH, 8'h0F);
    clk_en <= 1'b1;
    rd(GLITCH_FILTER_WIDTH, v & 8'hAF);
    wr(GLITCH_FILTER_WIDTH, 8'h20);
    wr(MSK, 8'h01);
    // Start then stop, with only the stop event unmasked
    u_bus.start_c();
    u_bus.hb();
    rd(GLITCH_FILTER_WIDTH, 8'h30);
    cy(1);
    ck("irq", irq, 1'b0);
    ck("module_irq", module_irq, 1'b1);
    // Module interrupt enable gates the line regardless of flags
    @(posedge ref_clk);
    module_irq_enable <= 1'b0;
    cy(1);
    ck("module_irq", module_irq, 1'b0);
    @(posedge ref_clk);
    module_irq_enable <= 1'b1;
    wr(GLITCH_FILTER_WIDTH, 8'h20);
    rd(GLITCH_FILTER_WIDTH, 8'h30);
    u_bus.stop_c();
    rd(GLITCH_FILTER_WIDTH, 8'h70);
    cy(1);
    ck("irq", irq, 1'b1);
    wr(GLITCH_FILTER_WIDTH, 8'h70);
    rd(GLITCH_FILTER_WIDTH, 8'h20);
    cy(1);
    ck("module_irq", module_irq, 1'b0);
    rd(STS, 8'h03);
    cy(3);
    ck("irq", irq, 1'b0);
    // Short glitch: absorbed by width 8, passed with filter bypassed
    wr(GLITCH_FILTER_WIDTH, 8'h08);
    u_bus.glitch(3);
    rd(GLITCH_FILTER_WIDTH, 8'h08);
    wr(GLITCH_FILTER_WIDTH, 8'h00);
    u_bus.glitch(3);
    rd(GLITCH_FILTER_WIDTH, 8'h50);
    wr(GLITCH_FILTER_WIDTH, 8'h50);
    // Holdoff off: ack at once in mid-byte
    u_bus.start_c();
    u_bus.bits(9'h0A4, 0, 2);
    req(1'b1);
    cy(2);
    ck("stop_ack", stop_ack, 1'b1);
    req(1'b0);
    cy(2);
    ck("stop_ack", stop_ack, 1'b0);
    u_bus.stop_c();
    u_bus.start_c();
    u_bus.bits(9'h0A4, 0, 8);
    u_bus.stop_c();
    rd(STS, 8'h0F);
    cy(2);
    ck("module_irq", module_irq, 1'b0);
    // Holdoff on: ack waits for the ninth clock of the byte
    wr(GLITCH_FILTER_WIDTH, 8'h80);
    u_bus.start_c();
    u_bus.bits(9'h0A4, 0, 2);
    req(1'b1);
    u_bus.hb();
    cy(1);
    ck("stop_ack", stop_ack, 1'b0);
    u_bus.bits(9'h0A4, 3, 7);
    u_bus.hb();
    cy(1);
    ck("stop_ack", stop_ack, 1'b0);
    u_bus.bits(9'h0A4, 8, 8);
    u_bus.hb();
    cy(1);
    ck("stop_ack", stop_ack, 1'b1);
    ck("module_irq", module_irq, 1'b1);
    // Stop mode gates the clock; the interrupt must survive to wakeup
    @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (8) @(posedge ref_clk);
    clk_en <= 1'b1;
    cy(1);
    ck("module_irq", module_irq, 1'b1);
    req(1'b0);
    cy(2);
    ck("stop_ack", stop_ack, 1'b0);
    // Controller disabled mid-byte: ack at once
    u_bus.bits(9'h0A4, 0, 2);
    ctrl_enable <= 1'b0;
    req(1'b1);
    cy(2);
    ck("stop_ack", stop_ack, 1'b1);
    req(1'b0);
    ctrl_enable <= 1'b1;
    u_bus.stop_c();
    // Idle bus: ack at once
    req(1'b1);
    cy(2);
    ck("stop_ack", stop_ack, 1'b1);
    req(1'b0);
    cy(2);
    ck("stop_ack", stop_ack, 1'b0);
    conclude();
  end
endmodule : tb
